/* logic/i2c_slave_status_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_status_engine
  import i2c_slave_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Master half reports lost arbitration in the address phase
  input wire logic master_arb_lost,
  // Serial clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    slave_state_e state;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic [7:0] own_addr;
    logic [7:0] status;
    logic enable;
    logic start_req;
    logic stop_req;
    logic si;
    logic aa;
    logic addressed;
    logic gc;
    logic read_mode;
    logic arb_lost;
    logic gc_byte_done;
    logic last_tx;
    logic tx_loaded;
    logic acked;
    logic scl_d;
    logic sda_d;
    logic scl_oe;
    logic sda_oe;
    logic line_low;
    logic [2:0] int_status;
    logic [2:0] int_mask;
    logic irq;
    logic [7:0] rdata;
  } core_s;

  core_s r;
  core_s n;
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic own_match;
  logic gc_match;
  logic [2:0] int_set;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .pin_in({scl_in, sda_in}),
    .pin_sync_out(pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];
  assign scl_rise = scl_s & ~r.scl_d;
  assign scl_fall = ~scl_s & r.scl_d;
  assign start_seen = r.scl_d & scl_s & r.sda_d & ~sda_s;
  assign stop_seen = r.scl_d & scl_s & ~r.sda_d & sda_s;
  assign own_match = (r.shift[7:1] == r.own_addr[7:1]);
  assign gc_match = (r.shift == RST_BYTE) & r.own_addr[BIT_GC_ENABLE];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    int_set = RST_INT;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    n.line_low = 1'b0;
    n.rdata = RST_BYTE;

    // Register reads answer in the following cycle; unmapped offsets read zero.
    if (reg_rd) begin
      case (reg_addr)
        OFS_CONTROL_SET: begin
          n.rdata[BIT_ENABLE] = r.enable;
          n.rdata[BIT_START] = r.start_req;
          n.rdata[BIT_STOP] = r.stop_req;
          n.rdata[BIT_EVENT] = r.si;
          n.rdata[BIT_ACK] = r.aa;
        end
        OFS_STATE_CODE: n.rdata = r.si ? r.status : ST_NO_INFO;
        OFS_SHIFT_DATA: n.rdata = r.data;
        OFS_OWN_ADDR: n.rdata = r.own_addr;
        OFS_INT_STATUS: n.rdata = {5'h00, r.int_status};
        OFS_INT_MASK: n.rdata = {5'h00, r.int_mask};
        default: n.rdata = RST_BYTE;
      endcase
    end

    // Software writes come first so that hardware events below win over a clear.
    if (reg_wr) begin
      case (reg_addr)
        OFS_CONTROL_SET: begin
          n.enable = r.enable | reg_wdata[BIT_ENABLE];
          n.start_req = r.start_req | reg_wdata[BIT_START];
          n.stop_req = r.stop_req | reg_wdata[BIT_STOP];
          n.aa = r.aa | reg_wdata[BIT_ACK];
        end
        OFS_CONTROL_CLEAR: begin
          n.enable = r.enable & ~reg_wdata[BIT_ENABLE];
          n.start_req = r.start_req & ~reg_wdata[BIT_START];
          n.si = r.si & ~reg_wdata[BIT_EVENT];
          n.aa = r.aa & ~reg_wdata[BIT_ACK];
        end
        OFS_SHIFT_DATA: n.data = reg_wdata;
        OFS_OWN_ADDR: n.own_addr = reg_wdata;
        OFS_INT_STATUS: n.int_status = r.int_status & ~reg_wdata[2:0];
        OFS_INT_MASK: n.int_mask = reg_wdata[2:0];
        default: n.int_mask = n.int_mask;
      endcase
    end

    if (master_arb_lost) begin
      n.arb_lost = 1'b1;
    end

    if (!r.enable) begin
      n.state = SL_IDLE;
      n.addressed = 1'b0;
      n.sda_oe = 1'b0;
    end else if (r.stop_req) begin
      // A stop request in slave mode releases the lines and returns the slave to the non-addressed idle state.
      n.state = SL_IDLE;
      n.addressed = 1'b0;
      n.sda_oe = 1'b0;
      n.stop_req = 1'b0;
    end else if (start_seen || stop_seen) begin
      if (r.addressed) begin
        n.si = 1'b1;
        n.status = ST_STOP_RESTART;
        int_set[INT_BUS_END] = 1'b1;
      end
      n.addressed = 1'b0;
      n.sda_oe = 1'b0;
      n.bitcnt = 4'h0;
      n.state = start_seen ? SL_ADDR : SL_IDLE;
    end else if (!r.si) begin
      case (r.state)
        SL_IDLE: n.state = SL_IDLE;
        SL_ADDR: begin
          if (scl_rise) begin
            n.shift = {r.shift[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == BITS_PER_BYTE) begin
            // A general call with the read bit set is not a valid address.
            if (r.aa && (own_match || gc_match)) begin
              n.addressed = 1'b1;
              n.gc = gc_match & ~own_match;
              n.read_mode = r.shift[0];
              n.sda_oe = 1'b1;
              n.state = SL_ADDR_ACK;
            end else begin
              n.state = SL_IDLE;
            end
          end
        end
        SL_ADDR_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.si = 1'b1;
            n.bitcnt = 4'h0;
            n.arb_lost = 1'b0;
            n.gc_byte_done = 1'b0;
            int_set[INT_ADDRESSED] = 1'b1;
            if (r.read_mode) begin
              n.status = r.arb_lost ? ST_ARB_OWN_READ : ST_OWN_READ;
              n.tx_loaded = 1'b0;
              n.state = SL_TX_DATA;
            end else begin
              if (r.gc) begin
                n.status = r.arb_lost ? ST_ARB_GC_WRITE : ST_GC_WRITE;
              end else begin
                n.status = r.arb_lost ? ST_ARB_OWN_WRITE : ST_OWN_WRITE;
              end
              n.state = SL_RX_DATA;
            end
          end
        end
        SL_RX_DATA: begin
          if (scl_rise) begin
            n.shift = {r.shift[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == BITS_PER_BYTE) begin
            // Hardware refuses every general-call byte after the first.
            n.acked = r.aa & ~(r.gc & r.gc_byte_done);
            n.sda_oe = r.aa & ~(r.gc & r.gc_byte_done);
            n.state = SL_RX_ACK;
          end
        end
        SL_RX_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.si = 1'b1;
            n.bitcnt = 4'h0;
            if (r.acked) begin
              n.data = r.shift;
              n.status = r.gc ? ST_GC_DATA_ACK : ST_OWN_DATA_ACK;
              n.gc_byte_done = r.gc;
              n.state = SL_RX_DATA;
            end else begin
              n.status = r.gc ? ST_GC_DATA_NACK : ST_OWN_DATA_NACK;
              n.addressed = 1'b0;
              n.state = SL_IDLE;
            end
          end
        end
        SL_TX_DATA: begin
          if (!r.tx_loaded) begin
            // Software has put the byte in place before releasing the flag.
            n.shift = r.data;
            n.last_tx = ~r.aa;
            n.sda_oe = ~r.data[7];
            n.tx_loaded = 1'b1;
          end else if (scl_fall) begin
            if (r.bitcnt == LAST_TX_BIT) begin
              n.sda_oe = 1'b0;
              n.bitcnt = 4'h0;
              n.state = SL_TX_ACK;
            end else begin
              n.shift = {r.shift[6:0], 1'b0};
              n.sda_oe = ~r.shift[6];
              n.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        SL_TX_ACK: begin
          if (scl_rise) begin
            n.acked = ~sda_s;
          end else if (scl_fall) begin
            n.si = 1'b1;
            if (!r.acked) begin
              n.status = ST_TX_NACK;
              n.addressed = 1'b0;
              n.state = SL_IDLE;
            end else if (r.last_tx) begin
              n.status = ST_TX_LAST_ACK;
              n.addressed = 1'b0;
              n.state = SL_IDLE;
            end else begin
              n.status = ST_TX_ACK;
              n.tx_loaded = 1'b0;
              n.state = SL_TX_DATA;
            end
          end
        end
        default: n.state = SL_IDLE;
      endcase
    end

    if (n.si && !r.si) begin
      int_set[INT_EVENT] = 1'b1;
    end
    n.int_status = n.int_status | int_set;
    n.irq = |(n.int_status & n.int_mask);
    // Stretching is kept to non-idle states, so a report after a stop never blocks the bus.
    n.scl_oe = n.si & (n.state != SL_IDLE) & n.enable;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.state <= SL_IDLE;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign scl_out = r.line_low;
  assign sda_out = r.line_low;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
  assign irq = r.irq;

endmodule // i2c_slave_status_engine
`default_nettype wire

/* logic/i2c_slave_pkg.sv */
// Notes on behaviour
// - After losing arbitration in the address phase and then acknowledging a general call, the status is 0x78.
// - A data byte received and acknowledged while addressed by the own address gives status 0x80.
// - A byte refused while addressed by the own address gives status 0x88, is dropped, and the slave becomes non-addressed.
// - An acknowledged data byte after a general call gives status 0x90, and only the first such byte is acknowledged.
// - A refused data byte after a general call gives status 0x98, is dropped, and the slave becomes non-addressed.
// - A stop or repeated start seen while addressed gives status 0xA0 and leaves the slave non-addressed with no data saved.
// - The own address with the read bit, acknowledged, gives status 0xA8 and starts slave transmission.
// - After losing arbitration in the address phase, being addressed for reading by the own address is acknowledged with status 0xB0.
// - A sent byte acknowledged by the master gives status 0xB8 and the next byte is expected in the data register.
// - A sent byte refused by the master gives status 0xC0 and the slave becomes non-addressed.
// - The acknowledged last byte of a slave transmission gives status 0xC8 and the slave becomes non-addressed.
// - Writing 0x14 to the control-set register releases the bus and returns the slave to the non-addressed state.
package i2c_slave_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_SET = 8'h00;
  localparam logic [7:0] OFS_STATE_CODE = 8'h04;
  localparam logic [7:0] OFS_SHIFT_DATA = 8'h08;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h0C;
  localparam logic [7:0] OFS_CONTROL_CLEAR = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Control and own-address bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 6;
  localparam int BIT_START = 5;
  localparam int BIT_STOP = 4;
  localparam int BIT_EVENT = 3;
  localparam int BIT_ACK = 2;
  localparam int BIT_GC_ENABLE = 0;

  // ----------------------------------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------------------------------
  localparam int INT_EVENT = 0;
  localparam int INT_ADDRESSED = 1;
  localparam int INT_BUS_END = 2;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OWN_WRITE = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_WRITE = 8'h68;
  localparam logic [7:0] ST_GC_WRITE = 8'h70;
  localparam logic [7:0] ST_ARB_GC_WRITE = 8'h78;
  localparam logic [7:0] ST_OWN_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] ST_STOP_RESTART = 8'hA0;
  localparam logic [7:0] ST_OWN_READ = 8'hA8;
  localparam logic [7:0] ST_ARB_OWN_READ = 8'hB0;
  localparam logic [7:0] ST_TX_ACK = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;
  localparam logic [7:0] ST_TX_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_NO_INFO = 8'hF8;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_INT = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_ADDR_ACK = 3'b011,
    SL_RX_DATA = 3'b010,
    SL_RX_ACK = 3'b110,
    SL_TX_DATA = 3'b111,
    SL_TX_ACK = 3'b101
  } slave_state_e;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import i2c_slave_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Raw pins and synchronised copies
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_sync_out
);

  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } sync_s;

  sync_s r;
  sync_s n;

  // A released open-drain line idles high, so both stages reset high.
  always_comb begin
    n = r;
    for (int i = 0; i < 2; i++) begin
      n.first[i] = pin_in[i];
      n.second[i] = r.first[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign pin_sync_out = r.second;

endmodule // pin_sync
`default_nettype wire

/* testbench/i2c_slave_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_properties
  import i2c_slave_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Arbitration
  input wire logic master_arb_lost,
  // Pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Interrupt
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A stop request drops the stretch one cycle after its write, with no flag clear.
  logic stop_wr_d;
  always_ff @(posedge clk) begin
    stop_wr_d <= reg_wr && reg_addr == OFS_CONTROL_SET && reg_wdata[BIT_STOP];
  end
  sequence clr_flag_wr;
    reg_wr && reg_addr == OFS_CONTROL_CLEAR && reg_wdata[BIT_EVENT];
  endsequence
  sequence lines_free;
    !scl_oe && !sda_oe;
  endsequence
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_scl_never_high: assert property (scl_out == 1'b0)
    else $error("clock pin driven high");
  a_sda_never_high: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_stretch_hold: assert property ((scl_oe && !reg_wr && !stop_wr_d) |=> scl_oe)
    else $error("clock stretch dropped without software");
  a_clear_release: assert property (clr_flag_wr |-> ##[1:2] !scl_oe)
    else $error("clock not released after flag clear");
  a_stretch_code: assert property ((reg_rd && reg_addr == OFS_STATE_CODE && scl_oe) |=>
    (reg_rdata inside {[ST_OWN_WRITE:ST_TX_LAST_ACK]} && reg_rdata[2:0] == 3'h0))
    else $error("stretch without a slave status");
  a_stop_release: assert property ((reg_wr && reg_addr == OFS_CONTROL_SET &&
    reg_wdata == 8'h14) |-> ##[1:2] lines_free)
    else $error("lines held after stop request");
  a_irq_masked: assert property ((reg_wr && reg_addr == OFS_INT_MASK &&
    reg_wdata == 8'h00) |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn |=> (!irq && !scl_oe && !sda_oe && reg_rdata == 8'h00))
    else $error("outputs active after reset");
endmodule // i2c_slave_properties
bind i2c_slave_status_engine i2c_slave_properties i_props (.clk(clk), .resetn(resetn),
  .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .master_arb_lost(master_arb_lost), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

/* testbench/i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Resolved bus lines
  input wire logic scl_line,
  input wire logic sda_line,
  // Open-drain pull-downs
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Releasing the clock late in the low phase gives the slave time to grab it for a stretch.
  task automatic clk_bit(input logic drv, output logic smp);
    #40 sda_low = !drv;
    #60 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #60 smp = sda_line;
    scl_low = 1'b1;
  endtask
  task automatic start_cond();
    #40 sda_low = 1'b0;
    #60 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #60 sda_low = 1'b1;
    #60 scl_low = 1'b1;
  endtask
  task automatic stop_cond();
    #40 sda_low = 1'b1;
    #60 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #60 sda_low = 1'b0;
    #100;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(!ack, s);
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  import i2c_slave_pkg::*;
  localparam logic [7:0] OWN_W = 8'h54;
  localparam logic [7:0] OWN_R = 8'h55;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic master_arb_lost = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, scl_low, sda_low, ak;
  logic [7:0] rv;
  wire logic scl_line;
  wire logic sda_line;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  // Pull-ups hold both lines high whenever nobody pulls them low.
  assign scl_line = !(scl_oe || scl_low);
  assign sda_line = !(sda_oe || sda_low);
  always #10 clk = ~clk;
  i2c_slave_status_engine i_i2c_slave_status_engine (.clk(clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .master_arb_lost(master_arb_lost), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));
  i2c_master_model bm (.scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    @(posedge clk); d = reg_rdata;
  endtask
  task automatic ev(input logic [7:0] code);
    logic [7:0] s;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 2000) begin @(posedge clk); i++; end
    rd(OFS_STATE_CODE, s);
    `CHK("state code", code, s)
    wr(OFS_INT_STATUS, 8'h07);
  endtask
  task automatic go(input logic [7:0] set_val);
    wr(OFS_CONTROL_SET, set_val);
    wr(OFS_CONTROL_CLEAR, 8'h08);
  endtask
  task automatic arb();
    @(posedge clk); master_arb_lost <= 1'b1;
    @(posedge clk); master_arb_lost <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_init();
    wr(OFS_OWN_ADDR, 8'h55);
    wr(OFS_INT_MASK, 8'h07);
    wr(OFS_CONTROL_SET, 8'h44);
    rd(OFS_CONTROL_SET, rv); `CHK("control", 8'h44, rv)
    rd(OFS_STATE_CODE, rv); `CHK("idle code", ST_NO_INFO, rv)
    rd(8'h40, rv); `CHK("unmapped", 8'h00, rv)
    // A write made while the clock enable is low must leave no trace.
    @(posedge clk); ce <= 1'b0;
    wr(OFS_SHIFT_DATA, 8'hC3);
    @(posedge clk); ce <= 1'b1;
    rd(OFS_SHIFT_DATA, rv); `CHK("frozen write", 8'h00, rv)
  endtask
  task automatic t_own_rx();
    bm.start_cond(); bm.put_byte(OWN_W, ak); ev(ST_OWN_WRITE);
    go(8'h04);
    bm.put_byte(8'hA5, ak); `CHK("data ack", 1'b1, ak)
    ev(ST_OWN_DATA_ACK);
    rd(OFS_SHIFT_DATA, rv); `CHK("rx data", 8'hA5, rv)
    wr(OFS_CONTROL_CLEAR, 8'h0C);
    bm.put_byte(8'h3C, ak); `CHK("refused ack", 1'b0, ak)
    ev(ST_OWN_DATA_NACK);
    rd(OFS_SHIFT_DATA, rv); `CHK("dropped byte", 8'hA5, rv)
    go(8'h04); bm.stop_cond();
    rd(OFS_STATE_CODE, rv); `CHK("no stop event", ST_NO_INFO, rv)
  endtask
  task automatic t_gc_arb();
    arb(); bm.start_cond(); bm.put_byte(8'h00, ak);
    ev(ST_ARB_GC_WRITE);
    go(8'h24);
    bm.put_byte(8'h11, ak); `CHK("gc ack", 1'b1, ak)
    ev(ST_GC_DATA_ACK);
    rd(OFS_SHIFT_DATA, rv); `CHK("gc data", 8'h11, rv)
    go(8'h04);
    bm.put_byte(8'h22, ak); `CHK("gc second ack", 1'b0, ak)
    ev(ST_GC_DATA_NACK);
    rd(OFS_SHIFT_DATA, rv); `CHK("gc dropped", 8'h11, rv)
    go(8'h04); bm.stop_cond();
  endtask
  task automatic t_tx();
    bm.start_cond(); bm.put_byte(OWN_W, ak); ev(ST_OWN_WRITE); go(8'h04);
    bm.start_cond(); ev(ST_STOP_RESTART);
    go(8'h04);
    bm.put_byte(OWN_R, ak); ev(ST_OWN_READ);
    wr(OFS_SHIFT_DATA, 8'h96); go(8'h04);
    bm.get_byte(1'b1, rv); `CHK("tx first", 8'h96, rv)
    ev(ST_TX_ACK);
    wr(OFS_SHIFT_DATA, 8'h5A); wr(OFS_CONTROL_CLEAR, 8'h0C);
    bm.get_byte(1'b1, rv); `CHK("tx last", 8'h5A, rv)
    ev(ST_TX_LAST_ACK);
    go(8'h04); bm.stop_cond();
  endtask
  task automatic t_tx_arb();
    arb(); bm.start_cond(); bm.put_byte(OWN_R, ak);
    ev(ST_ARB_OWN_READ);
    wr(OFS_SHIFT_DATA, 8'hF0); go(8'h24);
    bm.get_byte(1'b0, rv); `CHK("tx after arb", 8'hF0, rv)
    ev(ST_TX_NACK);
    go(8'h04); bm.stop_cond();
  endtask
  task automatic t_stop_req();
    wr(OFS_INT_MASK, 8'h00);
    bm.start_cond(); bm.put_byte(OWN_W, ak);
    repeat (20) @(posedge clk);
    `CHK("masked irq", 1'b0, irq)
    `CHK("stretch", 1'b1, scl_oe)
    wr(OFS_INT_MASK, 8'h07); repeat (2) @(posedge clk);
    `CHK("unmasked irq", 1'b1, irq)
    wr(OFS_INT_STATUS, 8'h07); repeat (2) @(posedge clk);
    `CHK("cleared irq", 1'b0, irq)
    wr(OFS_CONTROL_SET, 8'h14); repeat (3) @(posedge clk);
    `CHK("scl freed", 1'b0, scl_oe)
    `CHK("sda freed", 1'b0, sda_oe)
    go(8'h04); bm.stop_cond();
    rd(OFS_INT_STATUS, rv); `CHK("not addressed", 8'h00, rv)
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_init();
    t_own_rx();
    t_gc_arb();
    t_tx();
    t_tx_arb();
    t_stop_req();
    summarize();
  end
endmodule // tb
`default_nettype wire
